// ---- core/drsw_top.sv ----
// Purpose: power sequencing, protection and processor watchdog
// Assumes: every sense bit is asynchronous to mclk_i
// Notes: enable or channel 1 supply loss drops straight to off
`timescale 1ns/1ps
`default_nettype none
`include "drsw_params.svh"

module drsw_top #(
    parameter int unsigned WD_TIMEOUT_MS = `DRSW_WD_MS_100,
    parameter int unsigned WD_TIMEOUT_CYC = WD_TIMEOUT_MS * `DRSW_CLK_KHZ,
    parameter int unsigned RP_CYC = `DRSW_RP_CYC_DEF
) (
    input wire logic mclk_i,
    input wire logic rst_b_i,
    input wire drsw_pkg::drsw_sense_type sense_i,
    output drsw_pkg::drsw_drive_type drive_o,
    output logic pfo_o,
    output logic watchdog_reset_out_n_n_o,
    output logic pgood_o
);

    drsw_pkg::drsw_state_type q;
    drsw_pkg::drsw_state_type d;

    logic start_ok;
    logic rst_cond;
    logic kick_rise;
    logic kick_edge;

    always_comb begin
        d = q;
        // three-stage synchroniser, change taken when stages two and three agree
        d.s1 = sense_i;
        d.s2 = q.s1;
        d.s3 = q.s2;
        for (int i = 0; i < $bits(drsw_pkg::drsw_sense_type); i++) begin
            if (q.s2[i] == q.s3[i]) begin
                d.filt[i] = q.s3[i];
            end
        end

        // comparator hysteresis
        if (d.filt.pfi_lo) begin
            d.pf_ok = 1'b0;
        end else if (d.filt.pfi_hi) begin
            d.pf_ok = 1'b1;
        end
        if (d.filt.vm2_lo) begin
            d.vm2_ok = 1'b0;
        end else if (d.filt.vm2_hi) begin
            d.vm2_ok = 1'b1;
        end
        if (d.filt.temp_hot) begin
            d.tsd = 1'b1;
        end else if (d.filt.temp_cool) begin
            d.tsd = 1'b0;
        end
        for (int c = 0; c < 2; c++) begin
            if (d.filt.sup_lo[c]) begin
                d.sup_ok[c] = 1'b0;
            end else if (d.filt.sup_hi[c]) begin
                d.sup_ok[c] = 1'b1;
            end
            if (d.filt.fb_fall[c]) begin
                d.pg[c] = 1'b0;
            end else if (d.filt.fb_rise[c]) begin
                d.pg[c] = 1'b1;
            end
            // overvoltage: sink first, then park both switches
            if (!q.ov_sink[c] && !q.ov_hold[c] && d.filt.fb_ov[c]) begin
                d.ov_sink[c] = 1'b1;
            end else if (q.ov_sink[c] && d.filt.neg_ilim[c]) begin
                d.ov_sink[c] = 1'b0;
                d.ov_hold[c] = 1'b1;
            end else if (q.ov_hold[c] && d.filt.fb_ov_clr[c]) begin
                d.ov_hold[c] = 1'b0;
            end
        end

        // power sequencer
        start_ok = d.filt.en_hi && d.pf_ok && (&d.filt.fb_zero) && d.sup_ok[0];
        if (!d.filt.en_hi || !d.sup_ok[0]) begin
            d.seq = drsw_pkg::SEQ_OFF;
            d.seq_cnt = 10'h000;
        end else if (d.tsd && q.seq != drsw_pkg::SEQ_TSD) begin
            d.seq = drsw_pkg::SEQ_TSD;
            // channel 1 stays off if it was not yet running
            d.tsd_c1off = !q.drive.ch_en[0];
        end else begin
            case (q.seq)
                drsw_pkg::SEQ_OFF: begin
                    d.seq_cnt = 10'h000;
                    if (start_ok) begin
                        d.seq = drsw_pkg::SEQ_WAIT1;
                    end
                end
                drsw_pkg::SEQ_WAIT1: begin
                    d.seq_cnt = q.seq_cnt + 10'h001;
                    if (!start_ok) begin
                        d.seq = drsw_pkg::SEQ_OFF;
                        d.seq_cnt = 10'h000;
                    end else if (q.seq_cnt == 10'(`DRSW_CH1_DLY_CYC - 1)) begin
                        d.seq = drsw_pkg::SEQ_SS1;
                        d.seq_cnt = 10'h000;
                    end
                end
                drsw_pkg::SEQ_SS1: begin
                    d.seq_cnt = q.seq_cnt + 10'h001;
                    if (q.seq_cnt == 10'(`DRSW_SS_CYC - 1)) begin
                        d.seq = drsw_pkg::SEQ_WAIT2;
                        d.seq_cnt = 10'h000;
                    end
                end
                drsw_pkg::SEQ_WAIT2: begin
                    if (!d.pg[0]) begin
                        d.seq_cnt = 10'h000;
                    end else if (q.seq_cnt != 10'(`DRSW_CH2_DLY_CYC - 1)) begin
                        d.seq_cnt = q.seq_cnt + 10'h001;
                    end else if (d.vm2_ok && d.pf_ok && d.sup_ok[1]) begin
                        d.seq = drsw_pkg::SEQ_SS2;
                        d.seq_cnt = 10'h000;
                    end
                end
                drsw_pkg::SEQ_SS2, drsw_pkg::SEQ_RUN: begin
                    if (!d.vm2_ok) begin
                        d.seq = drsw_pkg::SEQ_PD2;
                    end else if (!d.sup_ok[1]) begin
                        d.seq = drsw_pkg::SEQ_WAIT2;
                        d.seq_cnt = 10'h000;
                    end else if (q.seq == drsw_pkg::SEQ_SS2) begin
                        d.seq_cnt = q.seq_cnt + 10'h001;
                        if (q.seq_cnt == 10'(`DRSW_SS_CYC - 1)) begin
                            d.seq = drsw_pkg::SEQ_RUN;
                        end
                    end
                end
                drsw_pkg::SEQ_PD2: begin
                    if (d.filt.fb_zero[1]) begin
                        d.seq = drsw_pkg::SEQ_PD1;
                    end
                end
                drsw_pkg::SEQ_PD1: begin
                    if (d.filt.fb_zero[0]) begin
                        d.seq = drsw_pkg::SEQ_OFF;
                    end
                end
                drsw_pkg::SEQ_TSD: begin
                    if (d.filt.fb_zero[1]) begin
                        d.tsd_c1off = 1'b1;
                    end
                    if (!d.tsd) begin
                        d.seq = drsw_pkg::SEQ_OFF;
                        d.seq_cnt = 10'h000;
                    end
                end
                default: begin
                    d.seq = drsw_pkg::SEQ_OFF;
                end
            endcase
        end

        // watchdog
        rst_cond = !d.pg[1];
        kick_rise = d.filt.kick && !q.filt.kick;
        kick_edge = d.filt.kick != q.filt.kick;
        case (q.wd)
            drsw_pkg::WD_HOLD: begin
                d.wd_cnt = 32'h0000_0000;
                if (!rst_cond) begin
                    d.wd = drsw_pkg::WD_PULSE;
                end
            end
            drsw_pkg::WD_PULSE: begin
                d.wd_cnt = q.wd_cnt + 32'h0000_0001;
                if (q.wd_cnt == 32'(RP_CYC - 1)) begin
                    d.wd = drsw_pkg::WD_IDLE;
                    d.wd_cnt = 32'h0000_0000;
                    d.wd_trip = 1'b0;
                end
            end
            drsw_pkg::WD_IDLE: begin
                if (kick_rise) begin
                    d.wd = drsw_pkg::WD_ARMED;
                end
            end
            drsw_pkg::WD_ARMED: begin
                if (kick_edge) begin
                    d.wd_cnt = 32'h0000_0000;
                end else if (q.wd_cnt == 32'(WD_TIMEOUT_CYC - 1)) begin
                    d.wd = drsw_pkg::WD_PULSE;
                    d.wd_cnt = 32'h0000_0000;
                    d.wd_trip = 1'b1;
                end else begin
                    d.wd_cnt = q.wd_cnt + 32'h0000_0001;
                end
            end
            default: begin
                d.wd = drsw_pkg::WD_HOLD;
            end
        endcase
        if (rst_cond) begin
            d.wd = drsw_pkg::WD_HOLD;
            d.wd_cnt = 32'h0000_0000;
            d.wd_trip = 1'b0;
        end

        // registered outputs
        d.power_fail_warning_out = d.pf_ok && !d.tsd;
        d.watchdog_reset_out_n_n = d.wd inside {drsw_pkg::WD_IDLE, drsw_pkg::WD_ARMED};
        d.pgood = (&d.pg) && !(d.filt.timer_rc && d.wd_trip);
        d.drive.ch_en[0] = d.seq inside {drsw_pkg::SEQ_SS1, drsw_pkg::SEQ_WAIT2,
            drsw_pkg::SEQ_SS2, drsw_pkg::SEQ_RUN, drsw_pkg::SEQ_PD2}
            || (d.seq == drsw_pkg::SEQ_TSD && !d.tsd_c1off);
        d.drive.ch_en[1] = d.seq inside {drsw_pkg::SEQ_SS2, drsw_pkg::SEQ_RUN};
        d.drive.soft_start[0] = d.seq == drsw_pkg::SEQ_SS1;
        d.drive.soft_start[1] = d.seq == drsw_pkg::SEQ_SS2;
        d.drive.feedback[1] = d.seq inside {drsw_pkg::SEQ_PD2, drsw_pkg::SEQ_TSD};
        d.drive.feedback[0] = d.seq == drsw_pkg::SEQ_PD1
            || (d.seq == drsw_pkg::SEQ_TSD && d.tsd_c1off);
        d.drive.hs_block = (d.ov_sink | d.ov_hold) & d.drive.ch_en;
        d.drive.ls_force = d.ov_sink & d.drive.ch_en;
    end

    always_ff @(posedge mclk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            q <= '0;
        end else begin
            q <= d;
        end
    end

    assign drive_o = q.drive;
    assign pfo_o = q.power_fail_warning_out;
    assign watchdog_reset_out_n_n_o = q.watchdog_reset_out_n_n;
    assign pgood_o = q.pgood;

    default clocking cb @(posedge mclk_i);
    endclocking
    default disable iff (!rst_b_i);

    a_pfo_follows_sense: assert property (
        !q.pf_ok |-> !pfo_o
    ) else $error("warning output high while sense is low");

    a_ch2_gated: assert property (
        drive_o.ch_en[1] |-> q.vm2_ok && q.sup_ok[1]
    ) else $error("channel 2 running without monitor or supply");

    a_kick_ignored: assert property (
        q.wd == drsw_pkg::WD_PULSE |=> q.wd != drsw_pkg::WD_ARMED
    ) else $error("watchdog armed during reset pulse");

    a_arm_on_rise: assert property (
        $rose(q.wd == drsw_pkg::WD_ARMED) |-> q.filt.kick && !$past(q.filt.kick)
    ) else $error("watchdog armed without rising kick edge");

    a_edge_restarts: assert property (
        q.wd == drsw_pkg::WD_ARMED && $past(q.wd) == drsw_pkg::WD_ARMED
            && q.filt.kick != $past(q.filt.kick) |-> q.wd_cnt == 32'h0000_0000
    ) else $error("kick edge did not restart timeout");

    a_timeout_exact: assert property (
        $past(q.wd) == drsw_pkg::WD_ARMED && q.wd == drsw_pkg::WD_PULSE
            |-> $past(q.wd_cnt) == 32'(WD_TIMEOUT_CYC - 1) && !watchdog_reset_out_n_n_o
    ) else $error("timeout reset at wrong count");

    a_pulse_length: assert property (
        $rose(watchdog_reset_out_n_n_o) |-> $past(q.wd_cnt) == 32'(RP_CYC - 1)
    ) else $error("reset pulse length wrong");

    a_uv_holds_reset: assert property (
        !q.pg[1] |-> !watchdog_reset_out_n_n_o && q.wd_cnt == 32'h0000_0000
    ) else $error("reset released with channel 2 feedback low");

    a_ch1_delay: assert property (
        $rose(q.seq == drsw_pkg::SEQ_SS1) |-> $past(q.seq_cnt) == 10'(`DRSW_CH1_DLY_CYC - 1)
    ) else $error("channel 1 start delay wrong");

    a_ch2_delay: assert property (
        $rose(q.seq == drsw_pkg::SEQ_SS2)
            |-> $past(q.seq_cnt) == 10'(`DRSW_CH2_DLY_CYC - 1) && $past(q.pg[0])
    ) else $error("channel 2 start delay wrong");

    a_ss_length: assert property (
        $rose(q.seq == drsw_pkg::SEQ_RUN) && $past(q.seq) == drsw_pkg::SEQ_SS2
            |-> $past(q.seq_cnt) == 10'(`DRSW_SS_CYC - 1)
    ) else $error("soft start length wrong");

    a_pd_order: assert property (
        $rose(q.seq == drsw_pkg::SEQ_PD1)
            |-> $past(q.seq) == drsw_pkg::SEQ_PD2 && q.filt.fb_zero[1]
    ) else $error("channel 1 shut before channel 2 discharged");

    a_ovp_hold: assert property (
        $rose(q.ov_hold[0]) |-> $past(q.ov_sink[0]) && !q.ov_sink[0]
    ) else $error("overvoltage hold without sink phase");

    a_tsd_warning: assert property (
        q.tsd |-> !pfo_o
    ) else $error("warning high in thermal shutdown");

    a_uvlo_off: assert property (
        !q.sup_ok[0] |-> drive_o.ch_en == 2'b00
    ) else $error("channel on with supply below lockout");

    a_reset_in_powerup: assert property (
        q.wd inside {drsw_pkg::WD_HOLD, drsw_pkg::WD_PULSE} |-> !watchdog_reset_out_n_n_o
    ) else $error("reset output released before watchdog active");

    a_hold_no_arm: assert property (
        q.wd == drsw_pkg::WD_HOLD |=> q.wd inside {drsw_pkg::WD_HOLD, drsw_pkg::WD_PULSE}
    ) else $error("watchdog left hold without reset pulse");

    a_hot_ch2_feedback: assert property (
        q.tsd && q.filt.en_hi && q.sup_ok[0] |-> !drive_o.ch_en[1] && drive_o.feedback[1]
    ) else $error("channel 2 not feeding back in thermal shutdown");

    a_tsd_ch1_order: assert property (
        q.seq == drsw_pkg::SEQ_TSD && $past(q.seq) == drsw_pkg::SEQ_TSD && $rose(q.tsd_c1off)
            |-> q.filt.fb_zero[1]
    ) else $error("channel 1 discharged before channel 2 fell");

    a_tsd_resets: assert property (
        q.seq == drsw_pkg::SEQ_TSD && !q.pg[1] |-> !watchdog_reset_out_n_n_o && !pgood_o
    ) else $error("reset or power good high in thermal shutdown");

    a_tsd_exit: assert property (
        $past(q.seq) == drsw_pkg::SEQ_TSD && q.seq != drsw_pkg::SEQ_TSD
            |-> q.seq == drsw_pkg::SEQ_OFF && drive_o.ch_en == 2'b00
    ) else $error("thermal exit skipped the soft start path");

    a_pgood_rails: assert property (
        !(&q.pg) |-> !pgood_o
    ) else $error("power good high with a rail low");

    a_rc_timeout: assert property (
        q.filt.timer_rc && q.wd_trip |-> !pgood_o
    ) else $error("power good high during timeout pulse");

    a_ov_sink_drive: assert property (
        q.ov_sink[0] && drive_o.ch_en[0] |-> drive_o.ls_force[0] && drive_o.hs_block[0]
    ) else $error("overvoltage sink not driving switches");

    c_reach_run: cover property (q.seq == drsw_pkg::SEQ_RUN);
    c_wd_timeout: cover property ($rose(q.wd_trip));
    c_thermal: cover property (q.seq == drsw_pkg::SEQ_TSD && q.tsd_c1off);
    c_power_down: cover property ($rose(q.seq == drsw_pkg::SEQ_PD1));
    c_rc_timeout: cover property (q.filt.timer_rc && q.wd_trip);

endmodule
`default_nettype wire

// ---- core/drsw_params.svh ----
// Purpose: constants for the dual rail sequencer and watchdog
// Assumes: 50 MHz oscillator clock, comparator results as digital levels
// Notes: timeout is chosen at build time through top-level parameters
`ifndef DRSW_PARAMS_SVH
`define DRSW_PARAMS_SVH

`define DRSW_CLK_KHZ 50000
`define DRSW_CH1_DLY_CYC 128
`define DRSW_CH2_DLY_CYC 256
`define DRSW_SS_CYC 512
`define DRSW_WD_MS_50 50
`define DRSW_WD_MS_100 100
`define DRSW_WD_MS_150 150
`define DRSW_WD_MS_200 200
`define DRSW_RP_CYC_DEF 10000
`define DRSW_KICK_MIN_NS 80
`define DRSW_CLK_NS 20
`define DRSW_KICK_MIN_CYC (`DRSW_KICK_MIN_NS / `DRSW_CLK_NS)

`endif

// ---- core/drsw_pkg.sv ----
// Purpose: shared types for the dual rail sequencer and watchdog
// Assumes: index 0 is channel 1, index 1 is channel 2
// Notes: sense bits are raw comparator levels before synchronising
package drsw_pkg;

    typedef struct packed {
        logic pfi_hi;          // sense above 0.6 V
        logic pfi_lo;          // sense below 0.575 V
        logic vm2_hi;          // monitor above 0.65 V
        logic vm2_lo;          // monitor below 0.6 V
        logic en_hi;           // enable above 1.2 V
        logic timer_rc;        // resistor-capacitor timer wiring
        logic [1:0] fb_zero;   // feedback below 48 mV
        logic [1:0] fb_rise;   // feedback above 96.5 %
        logic [1:0] fb_fall;   // feedback below 95 %
        logic [1:0] fb_ov;     // feedback at 0.7 V
        logic [1:0] fb_ov_clr; // feedback at 0.63 V
        logic [1:0] neg_ilim;  // negative current limit tripped
        logic [1:0] sup_hi;    // supply above 4.2 V
        logic [1:0] sup_lo;    // supply below 3.7 V
        logic temp_hot;        // above 150 C
        logic temp_cool;       // below 135 C
        logic kick;            // watchdog_kick_in level
    } drsw_sense_type;

    typedef struct packed {
        logic [1:0] ch_en;
        logic [1:0] soft_start;
        logic [1:0] feedback;  // energy feedback discharge
        logic [1:0] hs_block;
        logic [1:0] ls_force;
    } drsw_drive_type;

    typedef enum logic [3:0] {
        SEQ_OFF, SEQ_WAIT1, SEQ_SS1, SEQ_WAIT2, SEQ_SS2, SEQ_RUN, SEQ_PD2, SEQ_PD1, SEQ_TSD
    } drsw_seq_type;

    typedef enum logic [1:0] {
        WD_HOLD, WD_PULSE, WD_IDLE, WD_ARMED
    } drsw_wd_type;

    typedef struct packed {
        drsw_sense_type s1;
        drsw_sense_type s2;
        drsw_sense_type s3;
        drsw_sense_type filt;
        logic pf_ok;
        logic vm2_ok;
        logic tsd;
        logic tsd_c1off;
        logic [1:0] sup_ok;
        logic [1:0] pg;
        logic [1:0] ov_sink;
        logic [1:0] ov_hold;
        drsw_seq_type seq;
        logic [9:0] seq_cnt;
        drsw_wd_type wd;
        logic [31:0] wd_cnt;
        logic wd_trip;
        logic power_fail_warning_out;
        logic watchdog_reset_out_n_n;
        logic pgood;
        drsw_drive_type drive;
    } drsw_state_type;

endpackage

// ---- tb/drsw_host_model.sv ----
// Purpose: host processor model strobing the watchdog kick line
// Assumes: the host sits in reset while the reset line is low
// Notes: gap_i sets the cycles between kick edges; run_i low holds the level
`timescale 1ns/1ps
`default_nettype none

module drsw_host_model (
    input wire logic clk_i,
    input wire logic rst_n_i,
    input wire logic run_i,
    input wire logic [7:0] gap_i,
    output logic kick_o
);
    logic [7:0] cnt_q;

    // toggle within every timeout while running
    always @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            kick_o <= 1'b0;
            cnt_q <= 8'h00;
        end else if (run_i) begin
            if (cnt_q >= gap_i) begin
                kick_o <= ~kick_o;
                cnt_q <= 8'h00;
            end else begin
                cnt_q <= cnt_q + 8'h01;
            end
        end
    end
endmodule

`default_nettype wire

// ---- tb/test_dual_rail_sequencer_watchdog.sv ----
// Purpose: self-checking bench for the sequencer and watchdog
// Assumes: shortened watchdog timeout and reset pulse parameters
// Notes: output windows allow for the input synchroniser latency
`timescale 1ns/1ps
`default_nettype none

module test_dual_rail_sequencer_watchdog;
    localparam int WD = 200;
    localparam int RP = 20;
    localparam int PG = 0, RST = 1, POWER_FAIL_WARNING_OUT = 2, LS0 = 3, HS0 = 5, FB0 = 7, FB1 = 8;
    localparam int SS0 = 9, SS1 = 10, EN0 = 11, EN1 = 12;
    logic mclk_i = 1'b0;
    logic rst_b_i = 1'b0;
    drsw_pkg::drsw_sense_type sns = '0;
    drsw_pkg::drsw_sense_type sense;
    drsw_pkg::drsw_drive_type drive;
    logic power_fail_warning_out, watchdog_reset_out_n_n, pgood, kick;
    logic run = 1'b0;
    logic [7:0] gap = 8'h28;
    logic [12:0] probe;
    integer seed = 32'h80c19d8a;
    int mismatches = 0;
    int num_checks = 0;
    int n;

    always #10 mclk_i = ~mclk_i;

    always_comb begin
        sense = sns;
        sense.kick = kick;
    end

    assign probe = {drive, power_fail_warning_out, watchdog_reset_out_n_n, pgood};

    drsw_top #(.WD_TIMEOUT_CYC(WD), .RP_CYC(RP)) u_drsw_top (
        .mclk_i(mclk_i), .rst_b_i(rst_b_i), .sense_i(sense), .drive_o(drive),
        .pfo_o(power_fail_warning_out), .watchdog_reset_out_n_n_o(watchdog_reset_out_n_n), .pgood_o(pgood)
    );

    drsw_host_model u_drsw_host_model (
        .clk_i(mclk_i), .rst_n_i(watchdog_reset_out_n_n), .run_i(run), .gap_i(gap), .kick_o(kick)
    );

    // both rails good: only the timer wiring and a timeout pull power good down
    function automatic logic exp_pgood(input logic rc, input logic trip);
        return !(rc && trip);
    endfunction

    task automatic tick(input int c);
        repeat (c) @(posedge mclk_i);
        #1;
    endtask

    task automatic chk(input string what, input logic exp, input logic got);
        num_checks++;
        if (got !== exp) begin
            mismatches++;
            $display("[ERR] %s expected %b seen %b", what, exp, got);
        end
    endtask

    // wait for a level; want low means it must not appear within lo cycles
    task automatic wt(input string what, input int idx, input logic val,
                      input int lo, input int hi, input logic want);
        n = 0;
        while (n < hi && probe[idx] !== val) begin
            tick(1);
            n++;
        end
        chk(what, 1'b1, (n >= lo) && (!want || probe[idx] === val));
    endtask

    task automatic finish_test;
        $display("checks %0d mismatches %0d", num_checks, mismatches);
        if (mismatches == 0 && num_checks > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask

    initial begin
        #(20 * 40000);
        mismatches++;
        finish_test();
    end

    initial begin
        tick(20);
        chk("reset out in reset", 1'b0, watchdog_reset_out_n_n);
        rst_b_i = 1'b1;
        sns.en_hi = 1'b1;
        sns.pfi_hi = 1'b1;
        sns.vm2_hi = 1'b1;
        sns.fb_zero = 2'b11;
        sns.sup_hi = 2'b11;
        wt("ch1 start delay", EN0, 1'b1, 128, 140, 1'b1);
        chk("ch1 soft start", 1'b1, probe[SS0]);
        chk("reset out power-up", 1'b0, watchdog_reset_out_n_n);
        chk("warning released", 1'b1, power_fail_warning_out);
        sns.fb_zero = 2'b00;
        wt("ch1 soft start len", SS0, 1'b0, 510, 516, 1'b1);
        sns.fb_rise[0] = 1'b1;
        wt("ch2 start delay", EN1, 1'b1, 256, 266, 1'b1);
        chk("ch2 soft start", 1'b1, probe[SS1]);
        chk("reset out ch2 ramp", 1'b0, watchdog_reset_out_n_n);
        sns.fb_rise[1] = 1'b1;
        wt("reset pulse end", RST, 1'b1, RP, RP + 8, 1'b1);
        chk("power good", 1'b1, pgood);
        run = 1'b1;
        for (int i = 0; i < 30; i++) begin
            gap = (i == 3) ? 8'h03 : 8'd20 + 8'($random(seed) & 32'h7f);
            wt("kicked no reset", RST, 1'b0, 150, 150, 1'b0);
        end
        @(kick);
        #1;
        run = 1'b0;
        wt("timeout reset", RST, 1'b0, WD, WD + 8, 1'b1);
        wt("timeout pulse", RST, 1'b1, RP - 1, RP + 2, 1'b1);
        wt("idle not armed", RST, 1'b0, 3 * WD, 3 * WD, 1'b0);
        run = 1'b1;
        gap = 8'h32;
        sns.timer_rc = 1'b1;
        @(posedge kick);
        #1;
        run = 1'b0;
        wt("armed by rise", RST, 1'b0, WD, WD + 8, 1'b1);
        chk("rc timeout pgood", exp_pgood(1'b1, 1'b1), pgood);
        wt("second pulse", RST, 1'b1, RP - 1, RP + 2, 1'b1);
        chk("rc pulse done pgood", exp_pgood(1'b1, 1'b0), pgood);
        sns.timer_rc = 1'b0;
        run = 1'b1;
        sns.pfi_hi = 1'b0;
        wt("warning hysteresis", POWER_FAIL_WARNING_OUT, 1'b0, 30, 30, 1'b0);
        sns.pfi_lo = 1'b1;
        wt("warning low", POWER_FAIL_WARNING_OUT, 1'b0, 2, 8, 1'b1);
        sns.pfi_lo = 1'b0;
        wt("warning held", POWER_FAIL_WARNING_OUT, 1'b1, 30, 30, 1'b0);
        sns.pfi_hi = 1'b1;
        wt("warning high", POWER_FAIL_WARNING_OUT, 1'b1, 2, 8, 1'b1);
        sns.fb_ov[0] = 1'b1;
        wt("ov sink", LS0, 1'b1, 2, 8, 1'b1);
        chk("ov high off", 1'b1, probe[HS0]);
        sns.neg_ilim[0] = 1'b1;
        wt("ov both off", LS0, 1'b0, 2, 8, 1'b1);
        sns.fb_ov[0] = 1'b0;
        sns.neg_ilim[0] = 1'b0;
        wt("ov hold", HS0, 1'b0, 20, 20, 1'b0);
        sns.fb_ov_clr[0] = 1'b1;
        wt("ov release", HS0, 1'b0, 2, 8, 1'b1);
        sns.fb_ov_clr[0] = 1'b0;
        sns.sup_hi[1] = 1'b0;
        sns.sup_lo[1] = 1'b1;
        wt("ch2 supply off", EN1, 1'b0, 2, 8, 1'b1);
        sns.sup_lo[1] = 1'b0;
        sns.sup_hi[1] = 1'b1;
        wt("ch2 supply back", EN1, 1'b1, 2, 266, 1'b1);
        chk("ch2 restart soft", 1'b1, probe[SS1]);
        sns.fb_rise[1] = 1'b0;
        sns.fb_fall[1] = 1'b1;
        wt("low fb reset", RST, 1'b0, 2, 8, 1'b1);
        wt("low fb pgood", PG, 1'b0, 0, 8, 1'b1);
        wt("low fb held", RST, 1'b1, 2 * WD, 2 * WD, 1'b0);
        sns.fb_fall[1] = 1'b0;
        sns.fb_rise[1] = 1'b1;
        wt("fb good release", RST, 1'b1, RP, RP + 10, 1'b1);
        sns.vm2_hi = 1'b0;
        sns.vm2_lo = 1'b1;
        wt("pd ch2 off", EN1, 1'b0, 2, 8, 1'b1);
        chk("pd ch2 feedback", 1'b1, probe[FB1]);
        wt("pd ch1 held", EN0, 1'b0, 50, 50, 1'b0);
        sns.fb_zero[1] = 1'b1;
        wt("pd ch1 off", EN0, 1'b0, 2, 8, 1'b1);
        chk("pd ch1 feedback", 1'b1, probe[FB0]);
        sns.fb_rise = 2'b00;
        sns.fb_zero[0] = 1'b1;
        sns.vm2_lo = 1'b0;
        sns.vm2_hi = 1'b1;
        wt("restart ch1", EN0, 1'b1, 128, 145, 1'b1);
        sns.temp_hot = 1'b1;
        sns.fb_fall[1] = 1'b1;
        wt("hot warning", POWER_FAIL_WARNING_OUT, 1'b0, 2, 8, 1'b1);
        chk("hot ch2 off", 1'b0, probe[EN1]);
        chk("hot ch2 feedback", 1'b1, probe[FB1]);
        wt("hot reset", RST, 1'b0, 0, 8, 1'b1);
        wt("hot ch1 off", EN0, 1'b0, 0, 8, 1'b1);
        chk("hot ch1 discharge", 1'b1, probe[FB0]);
        chk("hot pgood", 1'b0, pgood);
        wt("hot stays off", EN0, 1'b1, 200, 200, 1'b0);
        sns.temp_hot = 1'b0;
        sns.temp_cool = 1'b1;
        wt("cool warning", POWER_FAIL_WARNING_OUT, 1'b1, 2, 8, 1'b1);
        wt("cool restart", EN0, 1'b1, 120, 150, 1'b1);
        chk("cool soft start", 1'b1, probe[SS0]);
        finish_test();
    end
endmodule

`default_nettype wire
